/* File: pkg/lmsf_pkg.sv */
// package of constants for the lin mode status flag block
// Behaviour
// R1: byte held sets rx available; data read clears
// R2: tx/rx mismatch sets phy error; reads clear
// R3: receive overrun sets overrun flag
// R4: autobaud counter overflow sets overrun and autobaud
// R5: receive data read clears overrun flag
// R6: missing stop bit sets framing error
// R7: sleep state, 4-bit low sets break
// R8: wait-break state, 11-bit break sets break
// R9: active state, 10-bit break sets break
// R10: status zero or data read clears break
// R11: tx holding empty until data write
// R12: tx idle only when shifter empty, done
// R13: autobaud done sets flag; zero in master
// R14: autobaud irq enable raises receive interrupt
// R15: status zero read clears autobaud flag
// R16: mode register: 3-bit select, 5-bit status
// R17: select chooses uart, filter, lin, revision view
// R18: lin view: noise bit, saturating break length
package lmsf_pkg;
  localparam logic [11:0] LMSF_ADDR_DATA = 12'hF40;
  localparam logic [11:0] LMSF_ADDR_STAT0 = 12'hF41;
  localparam logic [11:0] LMSF_ADDR_MODE = 12'hF44;
  // indices of printed offsets; byte address is four times the index
  localparam logic [11:0] LMSF_ADDR_CTRL = 12'hF50;
  localparam logic [11:0] LMSF_ADDR_IRQ_STAT = 12'hF51;
  localparam logic [11:0] LMSF_ADDR_IRQ_MASK = 12'hF52;
  localparam logic [11:0] LMSF_ADDR_EVENT = 12'hF53;
  localparam int LMSF_BIT_RDA = 7;
  localparam int LMSF_BIT_PLE = 6;
  localparam int LMSF_BIT_OVR = 5;
  localparam int LMSF_BIT_FE = 4;
  localparam int LMSF_BIT_BRK = 3;
  localparam int LMSF_BIT_THE = 2;
  localparam int LMSF_BIT_TXI = 1;
  localparam int LMSF_BIT_ATB = 0;
  localparam logic [7:0] LMSF_STAT0_RESET = 8'h06;
  localparam logic [7:0] LMSF_MODE_RESET = 8'h00;
  localparam logic [2:0] LMSF_SEL_UART = 3'h0;
  localparam logic [2:0] LMSF_SEL_FILTER = 3'h1;
  localparam logic [2:0] LMSF_SEL_LIN = 3'h2;
  localparam logic [2:0] LMSF_SEL_REV = 3'h7;
  localparam logic [4:0] LMSF_HW_REVISION = 5'h00;
  localparam logic [3:0] LMSF_BRK_SLEEP = 4'h4;
  localparam logic [3:0] LMSF_BRK_WAIT = 4'hB;
  localparam logic [3:0] LMSF_BRK_ACTIVE = 4'hA;
  localparam logic [3:0] LMSF_BRK_MAX = 4'hF;
  localparam logic [15:0] LMSF_BIT_TIME_DEFAULT = 16'h0364;
  typedef enum logic [1:0] {
    LMSF_LIN_SLEEP = 2'b00,
    LMSF_LIN_WAIT_BREAK = 2'b01,
    LMSF_LIN_ACTIVE = 2'b10,
    LMSF_LIN_OTHER = 2'b11
  } lmsf_lin_state_type;
endpackage : lmsf_pkg

/* File: verilog/lmsf_break_meter.sv */
// break length meter: counts bit times while the bus is low
`timescale 1ns/10ps
module lmsf_break_meter
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] bit_time,
  input wire logic rx_low,
  output logic [3:0] run_length,
  output logic [3:0] measured_break_length,
  output logic break_end
);
  import lmsf_pkg::*;
  logic [15:0] tick_cnt;
  logic was_low;
  wire bit_tick = rx_low && (tick_cnt >= bit_time - 16'h0001);
  wire ending = was_low && !rx_low;
  assign break_end = ending && (run_length != 4'h0);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 16'h0000;
      run_length <= 4'h0;
      measured_break_length <= 4'h0;
      was_low <= 1'b0;
    end
    else
    begin
      was_low <= rx_low;
      tick_cnt <= (!rx_low || bit_tick) ? 16'h0000 : tick_cnt + 16'h0001;
      if (!rx_low)
        run_length <= 4'h0;
      else if (bit_tick && run_length != LMSF_BRK_MAX)
        run_length <= run_length + 4'h1; // R18
      if (break_end)
        measured_break_length <= run_length;
    end
  end
endmodule : lmsf_break_meter

/* File: verilog/lmsf_status.sv */
// lin mode status flags with apb register access
`timescale 1ns/10ps
module lmsf_status
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic rx_byte_done,
  input wire logic [7:0] rx_byte,
  input wire logic rx_stop_bad,
  input wire logic tx_active,
  input wire logic tx_bit_out,
  input wire logic tx_sample,
  input wire logic tx_load,
  input wire logic tx_shift_empty,
  input wire logic autobaud_done,
  input wire logic baud_rate_counter_overflow,
  input wire logic noise_event,
  input wire lmsf_pkg::lmsf_lin_state_type lin_state,
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  output logic rx_interrupt,
  output logic irq
);
  import lmsf_pkg::*;

  // ****************************************
  // pin synchroniser
  // ****************************************
  // both stages reset to the idle bus level, so no false break follows reset
  logic rx_meta;
  logic rx_sync;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // ****************************************
  // apb decode
  // ****************************************
  // register index map, byte address four times the index:
  //   data   read gives the received byte, write fills the transmit byte
  //   stat0  read-only flags; a read clears those that it owns
  //   mode   view select in [7:5], read-only view in [4:0]
  //   ctrl   [0] autobaud irq enable, [1] slave, [31:16] bit time
  //   istat  sticky interrupt causes, a written one clears
  //   imask  interrupt enables, same layout as istat
  //   event  live break run length
  wire [11:0] reg_index = paddr[13:2];
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_data = reg_index == LMSF_ADDR_DATA;
  wire hit_stat0 = reg_index == LMSF_ADDR_STAT0;
  wire hit_mode = reg_index == LMSF_ADDR_MODE;
  wire hit_ctrl = reg_index == LMSF_ADDR_CTRL;
  wire hit_istat = reg_index == LMSF_ADDR_IRQ_STAT;
  wire hit_imask = reg_index == LMSF_ADDR_IRQ_MASK;
  wire hit_event = reg_index == LMSF_ADDR_EVENT;
  wire mapped = hit_data | hit_stat0 | hit_mode | hit_ctrl |
                hit_istat | hit_imask | hit_event;
  wire rd_data = rd && hit_data;
  wire rd_stat0 = rd && hit_stat0;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ****************************************
  // write strobes
  // ****************************************
  // one byte lane of one register, taken in the access phase
  function automatic logic lane_write
  (
    input logic wr_access,
    input logic hit,
    input logic [3:0] strb,
    input int lane
  );
    lane_write = wr_access && hit && strb[lane];
  endfunction : lane_write
  wire wr_data = lane_write(wr, hit_data, pstrb, 0);
  wire wr_mode = lane_write(wr, hit_mode, pstrb, 0);
  wire wr_flags = lane_write(wr, hit_ctrl, pstrb, 0);
  wire wr_time_lo = lane_write(wr, hit_ctrl, pstrb, 2);
  wire wr_time_hi = lane_write(wr, hit_ctrl, pstrb, 3);
  wire wr_imask = lane_write(wr, hit_imask, pstrb, 0);
  wire wr_istat = lane_write(wr, hit_istat, pstrb, 0);

  // ****************************************
  // control registers
  // ****************************************
  logic [2:0] status_view_select;
  logic autobaud_irq_enable;
  logic lin_slave;
  // bit time counts ref_clk cycles per bus bit
  logic [15:0] bit_time;
  logic [7:0] irq_mask;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_view_select <= LMSF_MODE_RESET[7:5];
      autobaud_irq_enable <= 1'b0;
      lin_slave <= 1'b0;
      bit_time <= LMSF_BIT_TIME_DEFAULT;
      irq_mask <= 8'h00;
    end
    else
    begin
      if (wr_mode)
        status_view_select <= pwdata[7:5]; // R16
      if (wr_flags)
      begin
        autobaud_irq_enable <= pwdata[0];
        lin_slave <= pwdata[1];
      end
      if (wr_time_lo)
        bit_time[7:0] <= pwdata[23:16];
      if (wr_time_hi)
        bit_time[15:8] <= pwdata[31:24];
      if (wr_imask)
        irq_mask <= pwdata[7:0];
    end
  end

  // ****************************************
  // break measurement
  // ****************************************
  logic [3:0] run_length;
  logic [3:0] measured_break_length;
  logic break_end;
  lmsf_break_meter i_lmsf_break_meter
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bit_time(bit_time),
    .rx_low(!rx_sync),
    .run_length(run_length),
    .measured_break_length(measured_break_length),
    .break_end(break_end)
  );
  // threshold in bit times for the current bus state; zero means no flag
  logic [3:0] brk_need;
  always_comb
  begin
    case (lin_state)
      LMSF_LIN_SLEEP: brk_need = LMSF_BRK_SLEEP; // R7
      LMSF_LIN_WAIT_BREAK: brk_need = LMSF_BRK_WAIT; // R8
      LMSF_LIN_ACTIVE: brk_need = LMSF_BRK_ACTIVE; // R9
      default: brk_need = 4'h0;
    endcase
  end
  // the flag fires once per low run, when the run first reaches its threshold
  logic brk_seen;
  wire brk_reach = (brk_need != 4'h0) && (run_length >= brk_need);
  wire brk_event = brk_reach && !brk_seen;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      brk_seen <= 1'b0;
    else
      brk_seen <= brk_reach;
  end

  // ****************************************
  // status flags
  // ****************************************
  // bus level against the bit sent, at the transmitter's sample point
  wire ple_event = tx_active && tx_sample && (rx_sync != tx_bit_out);
  logic [7:0] rx_data;
  logic [7:0] stat0;
  logic noise_seen;
  // counter overflow ends autobaud only for a slave
  wire ab_overflow = lin_slave && baud_rate_counter_overflow;
  wire ab_event = lin_slave && (autobaud_done || baud_rate_counter_overflow);
  // a byte lands while the last is unread and not read in this cycle
  wire rx_overrun = rx_byte_done && stat0[LMSF_BIT_RDA] && !rd_data;
  // one set and one clear request per status bit
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[LMSF_BIT_RDA] = rx_byte_done; // R1
    set_vec[LMSF_BIT_PLE] = ple_event; // R2
    set_vec[LMSF_BIT_OVR] = rx_overrun || ab_overflow; // R3 R4
    set_vec[LMSF_BIT_FE] = rx_byte_done && rx_stop_bad; // R6
    set_vec[LMSF_BIT_BRK] = brk_event;
    set_vec[LMSF_BIT_ATB] = ab_event; // R13
    clr_vec = 8'h00;
    clr_vec[LMSF_BIT_RDA] = rd_data; // R1
    clr_vec[LMSF_BIT_PLE] = rd_data || rd_stat0; // R2
    clr_vec[LMSF_BIT_OVR] = rd_data; // R5
    clr_vec[LMSF_BIT_FE] = rd_data; // R6
    clr_vec[LMSF_BIT_BRK] = rd_data || rd_stat0; // R10
    clr_vec[LMSF_BIT_ATB] = rd_stat0 || !lin_slave; // R15
  end
  wire [7:0] next_stat0;

  // ****************************************
  // flag and data registers
  // ****************************************
  // a write fills the holding byte; a load by the shifter empties it
  logic tx_holding_empty;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat0 <= LMSF_STAT0_RESET;
      rx_data <= 8'h00;
      tx_data <= 8'h00;
      tx_holding_empty <= 1'b1;
      noise_seen <= 1'b0;
    end
    else
    begin
      stat0 <= next_stat0;
      if (rx_byte_done)
        rx_data <= rx_byte;
      if (wr_data)
      begin
        tx_data <= pwdata[7:0];
        tx_holding_empty <= 1'b0; // R11
      end
      else if (tx_load)
        tx_holding_empty <= 1'b1; // R11
      if (rx_byte_done)
        noise_seen <= noise_event;
    end
  end

  // ****************************************
  // status views
  // ****************************************
  assign tx_data_valid = !tx_holding_empty;
  // a queued byte counts as a transfer in progress
  wire tx_idle = tx_shift_empty && !tx_active && tx_holding_empty; // R12
  wire atb_view = stat0[LMSF_BIT_ATB] && lin_slave; // R13
  wire [7:0] stat0_view = {stat0[7:3], tx_holding_empty, tx_idle, atb_view};

  // ****************************************
  // interrupts
  // ****************************************
  logic [7:0] irq_stat;
  logic ab_prev;
  // cause bits, msb first
  wire [7:0] irq_set =
  {
    2'b00,
    break_end,
    brk_event,
    ple_event,
    rx_overrun,
    ab_event,
    rx_byte_done
  };
  wire [7:0] irq_clr = wr_istat ? pwdata[7:0] : 8'h00;
  wire [7:0] next_irq_stat;
  wire ab_rise = stat0[LMSF_BIT_ATB] && !ab_prev;

  // ****************************************
  // sticky update
  // ****************************************
  // an event in the same cycle as its clear wins
  genvar flag;
  generate
    for (flag = 0; flag < 8; flag = flag + 1)
    begin : g_sticky
      assign next_stat0[flag] = set_vec[flag] || (stat0[flag] && !clr_vec[flag]);
      assign next_irq_stat[flag] = irq_set[flag] || (irq_stat[flag] && !irq_clr[flag]);
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= 8'h00;
      ab_prev <= 1'b0;
      rx_interrupt <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      ab_prev <= stat0[LMSF_BIT_ATB];
      rx_interrupt <= autobaud_irq_enable && ab_rise; // R14
    end
  end
  // level output: any unmasked cause still pending
  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // read mux
  // ****************************************
  // codes 3 to 6 are reserved and read zero
  logic [4:0] mode_status;
  always_comb
  begin
    case (status_view_select)
      LMSF_SEL_UART: mode_status = 5'h00;
      LMSF_SEL_FILTER: mode_status = {noise_seen, 4'h0}; // R17
      LMSF_SEL_LIN: mode_status = {noise_seen, measured_break_length}; // R18
      LMSF_SEL_REV: mode_status = LMSF_HW_REVISION; // R17
      default: mode_status = 5'h00;
    endcase
  end
  wire [7:0] rd_byte = hit_data ? rx_data :
                       hit_stat0 ? stat0_view :
                       hit_mode ? {status_view_select, mode_status} : // R16
                       hit_ctrl ? 8'h00 :
                       hit_istat ? irq_stat :
                       hit_imask ? irq_mask :
                       hit_event ? {4'h0, run_length} : 8'h00;
  wire [31:0] ctrl_word = {bit_time, 14'h0000, lin_slave, autobaud_irq_enable};
  wire [31:0] rd_word = hit_ctrl ?
                        ctrl_word :
                        {24'h000000, rd_byte};
  // taken in the setup cycle: a read returns the flags before its own clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_word;
  end
endmodule : lmsf_status

/* File: tb/lmsf_status_monitor.sv */
// concurrent checks on the lin status block ports
`timescale 1ns/10ps
module lmsf_status_monitor
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_byte_done,
  input wire logic tx_load,
  input wire logic autobaud_done,
  input wire logic baud_rate_counter_overflow,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  input wire logic rx_interrupt
);
  import lmsf_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire [11:0] idx = paddr[13:2];
  wire wr_data = acc && pwrite && pstrb[0] && idx == LMSF_ADDR_DATA;
  wire rd_setup = psel && !penable && !pwrite;
  wire ab_any = autobaud_done || baud_rate_counter_overflow;
  wire [7:0] wbyte = pwdata[7:0];
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_unmapped; acc && idx == 12'hF60 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
  property p_hold_full; wr_data && !tx_load |=> tx_data_valid && tx_data == $past(wbyte); endproperty
  a_hold_full: assert property (p_hold_full) else $error("data write not held");
  property p_hold_take; tx_load && !wr_data |=> !tx_data_valid; endproperty
  a_hold_take: assert property (p_hold_take) else $error("holding not emptied by load");
  property p_irq_cause; rx_interrupt |-> $past(ab_any, 2); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("receive interrupt without autobaud");
  property p_irq_pulse; rx_interrupt |=> !rx_interrupt; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("receive interrupt too long");
  property p_rda; rx_byte_done ##1 !acc ##1 (rd_setup && idx == LMSF_ADDR_STAT0) |=> prdata[7]; endproperty
  a_rda: assert property (p_rda) else $error("byte not flagged available");
  property p_mode_hi; rd_setup && idx == LMSF_ADDR_MODE |=> prdata[31:8] == 24'h000000; endproperty
  a_mode_hi: assert property (p_mode_hi) else $error("mode register upper bits set");
  c_irq: cover property (rx_interrupt);
  c_err: cover property (acc && pslverr);
  c_load: cover property (tx_load && tx_data_valid);
endmodule : lmsf_status_monitor
bind lmsf_status lmsf_status_monitor i_lmsf_status_monitor(.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_byte_done, .tx_load, .autobaud_done, .baud_rate_counter_overflow,
  .tx_data, .tx_data_valid, .rx_interrupt);

/* File: tb/lmsf_lin_node.sv */
// far-side lin node: echoes the transmit bit or holds the bus low
`timescale 1ns/10ps
module lmsf_lin_node
(
  input wire logic ref_clk,
  input wire logic tx_active,
  input wire logic tx_bit_out,
  input wire logic flip,
  output logic rx_pin
);
  logic low = 1'b0;
  // recessive bus idles high through the pull-up; flip models a clash
  assign rx_pin = low ? 1'b0 : (tx_active ? tx_bit_out ^ flip : 1'b1);
  task automatic hold_low(input int n);
    low <= 1'b1;
    repeat (n) @(posedge ref_clk);
    low <= 1'b0;
  endtask : hold_low
endmodule : lmsf_lin_node

/* File: tb/lmsf_status_bench.sv */
// self-checking bench for the lin status flag block
`timescale 1ns/10ps
module lmsf_status_bench;
  import lmsf_pkg::*;
  localparam logic [11:0] S0 = LMSF_ADDR_STAT0;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rx_pin, er, flip = 0;
  logic rx_stop_bad = 0, tx_active = 0, tx_bit_out = 1, tx_shift_empty = 1, noise_event = 0;
  logic tx_data_valid, rx_interrupt, irq;
  logic [4:0] pv = 5'h00;
  wire rx_byte_done = pv[0], autobaud_done = pv[1], baud_rate_counter_overflow = pv[2];
  wire tx_sample = pv[3], tx_load = pv[4];
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [3:0] pstrb = 0;
  logic [7:0] rx_byte = 0, tx_data;
  lmsf_lin_state_type lin_state = LMSF_LIN_OTHER;
  int bad_count = 0, tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  lmsf_status i_lmsf_status(.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .rx_pin, .rx_byte_done, .rx_byte, .rx_stop_bad, .tx_active, .tx_bit_out, .tx_sample,
    .tx_load, .tx_shift_empty, .autobaud_done, .baud_rate_counter_overflow, .noise_event, .lin_state,
    .tx_data, .tx_data_valid, .rx_interrupt, .irq);
  lmsf_lin_node i_lmsf_lin_node(.ref_clk, .tx_active, .tx_bit_out, .flip, .rx_pin);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    bad_count += int'(g !== e);
    if (g !== e)
      $display("[FAIL] %s expected %h seen %h", n, e, g);
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge ref_clk) penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 0);
    chk("register", {24'h000000, e}, rdat);
  endtask : rd
  // one-cycle pulse: 0 byte, 1 autobaud, 2 overflow, 3 compare, 4 load
  task automatic pls(input int k);
    pv <= 5'h01 << k;
    @(posedge ref_clk) pv <= 5'h00;
    @(posedge ref_clk);
  endtask : pls
  task automatic t_rx;
    apb(1, LMSF_ADDR_IRQ_MASK, 1);
    rx_byte <= 8'h5A;
    rx_stop_bad <= 1;
    pls(0);
    chk("irq", 1, irq);
    rd(S0, 8'h96);
    rd(LMSF_ADDR_DATA, 8'h5A);
    rd(S0, 8'h06);
    apb(1, LMSF_ADDR_IRQ_STAT, 1);
    chk("irq", 0, irq);
    rx_stop_bad <= 0;
    noise_event <= 1;
    pls(0);
    pls(0);
    rd(S0, 8'hA6);
    apb(0, LMSF_ADDR_DATA, 0);
    rd(S0, 8'h06);
  endtask : t_rx
  task automatic t_ab;
    logic [31:0] n = 0;
    apb(1, LMSF_ADDR_CTRL, 32'h0004_0003);
    pls(1);
    repeat (4) @(posedge ref_clk) n += rx_interrupt;
    chk("rx_interrupt", 1, n);
    rd(S0, 8'h07);
    rd(S0, 8'h06);
    pls(2);
    rd(S0, 8'h27);
    rd(S0, 8'h26);
    apb(0, LMSF_ADDR_DATA, 0);
    rd(S0, 8'h06);
    apb(1, LMSF_ADDR_CTRL, 32'h0004_0001);
    pls(1);
    rd(S0, 8'h06);
  endtask : t_ab
  task automatic brk(input lmsf_lin_state_type s, input int n, input logic [7:0] e);
    lin_state <= s;
    i_lmsf_lin_node.hold_low(n);
    repeat (6) @(posedge ref_clk);
    rd(S0, e);
  endtask : brk
  // bit time is 4 clocks from here on
  task automatic t_brk;
    brk(LMSF_LIN_SLEEP, 12, 8'h06);
    brk(LMSF_LIN_SLEEP, 22, 8'h0E);
    brk(LMSF_LIN_WAIT_BREAK, 40, 8'h06);
    brk(LMSF_LIN_WAIT_BREAK, 50, 8'h0E);
    brk(LMSF_LIN_ACTIVE, 36, 8'h06);
    brk(LMSF_LIN_ACTIVE, 80, 8'h0E);
    apb(1, LMSF_ADDR_MODE, 32'h40);
    rd(LMSF_ADDR_MODE, 8'h5F);
    apb(1, LMSF_ADDR_MODE, 32'h20);
    rd(LMSF_ADDR_MODE, 8'h30);
    apb(1, LMSF_ADDR_MODE, 32'h60);
    rd(LMSF_ADDR_MODE, 8'h60);
    apb(1, LMSF_ADDR_MODE, 32'hE0);
    rd(LMSF_ADDR_MODE, {3'h7, LMSF_HW_REVISION});
    lin_state <= LMSF_LIN_OTHER;
  endtask : t_brk
  task automatic t_tx;
    apb(1, LMSF_ADDR_DATA, 32'hA5);
    chk("tx_data", 32'hA5, tx_data);
    chk("tx_data_valid", 1, tx_data_valid);
    rd(S0, 8'h00);
    tx_shift_empty <= 0;
    tx_active <= 1;
    pls(4);
    chk("tx_data_valid", 0, tx_data_valid);
    flip <= 1;
    repeat (3) @(posedge ref_clk);
    pls(3);
    rd(S0, 8'h44);
    rd(S0, 8'h04);
    pls(3);
    apb(0, LMSF_ADDR_DATA, 0);
    rd(S0, 8'h04);
    {flip, tx_active, tx_shift_empty} <= 3'h1;
    apb(0, 12'hF60, 0);
    chk("pslverr", 1, er);
    chk("unmapped", 0, rdat);
    rd(S0, 8'h06);
  endtask : t_tx
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    rd(S0, 8'h06);
    rd(LMSF_ADDR_MODE, 8'h00);
    t_rx;
    t_ab;
    t_brk;
    t_tx;
    end_sim;
  end
  initial
  begin
    #50us;
    bad_count++;
    end_sim;
  end
endmodule : lmsf_status_bench
